// *** hw/gps_consts.svh ***
// offsets, field positions, reset values and sizes for the per-port phy status/extended-access bank
// assumes a 16-bit register port addressed by the printed byte offsets
`ifndef GPS_CONSTS_SVH
`define GPS_CONSTS_SVH

`define GPS_ADDR_W 12
`define GPS_DATA_W 16

`define GPS_OFS_LINK_STATUS 12'h114
`define GPS_OFS_SETUP 12'h11a
`define GPS_OFS_WINDOW 12'h11c
`define GPS_OFS_INT_STATUS 12'h130
`define GPS_OFS_INT_MASK 12'h132

`define GPS_BIT_MS_FAULT 15
`define GPS_BIT_MS_MASTER 14
`define GPS_BIT_LOCAL_OK 13
`define GPS_BIT_REMOTE_OK 12
`define GPS_BIT_LP_FD 11
`define GPS_BIT_LP_HD 10
`define GPS_IDLE_CNT_W 8

`define GPS_SETUP_MODE_HI 15
`define GPS_SETUP_MODE_LO 14
`define GPS_DEV_W 5

`define GPS_SETUP_RESET 16'h0000
`define GPS_WINDOW_RESET 16'h0000
`define GPS_IDLE_CNT_MAX 8'hff

`define GPS_IDX_STORE_W 4
`define GPS_STORE_DEPTH 512

`define GPS_INT_W 4
`define GPS_INT_MS_FAULT 0
`define GPS_INT_IDLE_ERR 1
`define GPS_INT_LOCAL_LOSS 2
`define GPS_INT_REMOTE_LOSS 3

`endif

// *** hw/gps_pkg.sv ***
// types shared by the status/extended-access bank
// assumes nothing beyond the constants header
package gps_pkg;
   typedef enum logic [1:0] {
      GPS_MODE_INDEX,
      GPS_MODE_DATA,
      GPS_MODE_INC_RW,
      GPS_MODE_INC_WR
   } gps_op_mode_t;
endpackage : gps_pkg

// *** hw/gps_idle_cnt.sv ***
// idle error counter, saturating, cleared by a read of the status register
// assumes sym_valid_i marks one symbol period per pulse on clk_i
`timescale 1ns/100ps
`include "gps_consts.svh"
module gps_idle_cnt (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sym_valid_i,
   input wire logic idle_rx_i,
   input wire logic send_n_i,
   input wire logic rx_err_i,
   input wire logic clear_i,
   output logic [`GPS_IDLE_CNT_W-1:0] count_o,
   output logic hit_o
);
   logic hit;

   // only idles received with rx_err_i while the transmitter sends Send_N count
   assign hit = sym_valid_i && idle_rx_i && send_n_i && rx_err_i;
   assign hit_o = hit;

   // an error in the clearing cycle survives as a count of one
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o <= '0;
      end else if (clear_i) begin
         count_o <= hit ? `GPS_IDLE_CNT_W'(1) : '0;
      end else if (hit && count_o != `GPS_IDLE_CNT_MAX) begin
         count_o <= count_o + `GPS_IDLE_CNT_W'(1);
      end
   end
endmodule : gps_idle_cnt

// *** hw/gps_mmd_store.sv ***
// backing store for the extended register spaces, one word per device and low 4 index bits
// assumes the caller gives a combined address; read is combinational, write on the clock
`timescale 1ns/100ps
`include "gps_consts.svh"
module gps_mmd_store (
   input wire logic clk_i,
   input wire logic [`GPS_DEV_W+`GPS_IDX_STORE_W-1:0] addr_i,
   input wire logic wr_i,
   input wire logic [`GPS_DATA_W-1:0] wr_data_i,
   output logic [`GPS_DATA_W-1:0] rd_data_o
);
   // no reset: contents are undefined until software writes them
   logic [`GPS_DATA_W-1:0] mem [`GPS_STORE_DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= wr_data_i;
      end
   end

   assign rd_data_o = mem[addr_i];
endmodule : gps_mmd_store

// *** hw/gps_top.sv ***
// per-port gigabit status register, extended-space setup/window pair and interrupt
// assumes status inputs come from phy logic on clk_i; register port reads answer one cycle later
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "gps_consts.svh"
module gps_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [`GPS_ADDR_W-1:0] addr_i,
   input wire logic [`GPS_DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`GPS_DATA_W-1:0] rd_data_o,
   input wire logic ms_fault_i,
   input wire logic ms_master_i,
   input wire logic local_rx_ok_i,
   input wire logic remote_rx_ok_i,
   input wire logic lp_fd_i,
   input wire logic lp_hd_i,
   input wire logic sym_valid_i,
   input wire logic idle_rx_i,
   input wire logic send_n_i,
   input wire logic rx_err_i,
   output logic [1:0] op_mode_o,
   output logic [`GPS_DEV_W-1:0] dev_addr_o,
   output logic [`GPS_DATA_W-1:0] reg_index_o,
   output logic irq_o
);
   logic sel_status;
   logic sel_setup;
   logic sel_window;
   logic sel_istat;
   logic sel_imask;
   logic ms_fault_r;
   logic ms_master_r;
   logic local_ok_r;
   logic remote_ok_r;
   logic lp_fd_r;
   logic lp_hd_r;
   logic local_ok_d_r;
   logic remote_ok_d_r;
   logic [`GPS_DATA_W-1:0] setup_r;
   logic [`GPS_DATA_W-1:0] index_r;
   logic [`GPS_DATA_W-1:0] index_nxt;
   logic [`GPS_INT_W-1:0] int_status_r;
   logic [`GPS_INT_W-1:0] int_mask_r;
   logic [`GPS_INT_W-1:0] int_event;
   logic [`GPS_IDLE_CNT_W-1:0] idle_count;
   logic idle_hit;
   logic status_rd;
   logic win_rd;
   logic win_wr;
   logic [`GPS_DATA_W-1:0] store_rd_data;
   logic [`GPS_DATA_W-1:0] status_word;
   logic [`GPS_DATA_W-1:0] rd_mux;
   gps_pkg::gps_op_mode_t mode;

   // true when the address matches a register offset
   function automatic logic hit_of(input logic [`GPS_ADDR_W-1:0] a, input logic [`GPS_ADDR_W-1:0] ofs);
      hit_of = (a == ofs);
   endfunction : hit_of

   // whether a window access of the given kind advances the index
   function automatic logic advances(input gps_pkg::gps_op_mode_t m, input logic is_wr);
      case (m)
         gps_pkg::GPS_MODE_INDEX: advances = 1'b0;
         gps_pkg::GPS_MODE_DATA: advances = 1'b0;
         gps_pkg::GPS_MODE_INC_RW: advances = 1'b1;
         gps_pkg::GPS_MODE_INC_WR: advances = is_wr;
         default: advances = 1'b0;
      endcase
   endfunction : advances

   assign sel_status = hit_of(addr_i, `GPS_OFS_LINK_STATUS);
   assign sel_setup = hit_of(addr_i, `GPS_OFS_SETUP);
   assign sel_window = hit_of(addr_i, `GPS_OFS_WINDOW);
   assign sel_istat = hit_of(addr_i, `GPS_OFS_INT_STATUS);
   assign sel_imask = hit_of(addr_i, `GPS_OFS_INT_MASK);

   assign mode = gps_pkg::gps_op_mode_t'(setup_r[`GPS_SETUP_MODE_HI:`GPS_SETUP_MODE_LO]);
   assign status_rd = rd_i && sel_status;
   assign win_rd = rd_i && sel_window;
   assign win_wr = wr_i && sel_window;

   // live status mirrors, sampled once so a read sees one coherent word
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ms_master_r <= 1'b0;
         local_ok_r <= 1'b0;
         remote_ok_r <= 1'b0;
         lp_fd_r <= 1'b0;
         lp_hd_r <= 1'b0;
      end else begin
         ms_master_r <= ms_master_i;
         local_ok_r <= local_rx_ok_i;
         remote_ok_r <= remote_rx_ok_i;
         lp_fd_r <= lp_fd_i;
         lp_hd_r <= lp_hd_i;
      end
   end

   // latch-high fault: a read clears it, but a fault present in that cycle keeps it set
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ms_fault_r <= 1'b0;
      end else if (ms_fault_i) begin
         ms_fault_r <= 1'b1;
      end else if (status_rd) begin
         ms_fault_r <= 1'b0;
      end
   end

   gps_idle_cnt u_idle_cnt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sym_valid_i(sym_valid_i),
      .idle_rx_i(idle_rx_i),
      .send_n_i(send_n_i),
      .rx_err_i(rx_err_i),
      .clear_i(status_rd),
      .count_o(idle_count),
      .hit_o(idle_hit)
   );

   always_comb begin
      status_word = '0;
      status_word[`GPS_BIT_MS_FAULT] = ms_fault_r;
      status_word[`GPS_BIT_MS_MASTER] = ms_master_r;
      status_word[`GPS_BIT_LOCAL_OK] = local_ok_r;
      status_word[`GPS_BIT_REMOTE_OK] = remote_ok_r;
      status_word[`GPS_BIT_LP_FD] = lp_fd_r;
      status_word[`GPS_BIT_LP_HD] = lp_hd_r;
      status_word[`GPS_IDLE_CNT_W-1:0] = idle_count;
   end

   // setup keeps all 16 bits; the reserved middle field reads back what was written
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         setup_r <= `GPS_SETUP_RESET;
      end else if (wr_i && sel_setup) begin
         setup_r <= wr_data_i;
      end
   end

   always_comb begin
      index_nxt = index_r;
      if (win_wr && mode == gps_pkg::GPS_MODE_INDEX) begin
         index_nxt = wr_data_i;
      end else if ((win_wr && advances(mode, 1'b1)) || (win_rd && advances(mode, 1'b0))) begin
         index_nxt = index_r + `GPS_DATA_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         index_r <= `GPS_WINDOW_RESET;
      end else begin
         index_r <= index_nxt;
      end
   end

   // only low index bits reach the store; higher indices alias, which keeps the array small
   gps_mmd_store u_store (
      .clk_i(clk_i),
      .addr_i({setup_r[`GPS_DEV_W-1:0], index_r[`GPS_IDX_STORE_W-1:0]}),
      .wr_i(win_wr && mode != gps_pkg::GPS_MODE_INDEX),
      .wr_data_i(wr_data_i),
      .rd_data_o(store_rd_data)
   );

   // interrupt sources: fault rise, idle error, loss of local or remote receiver
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         local_ok_d_r <= 1'b0;
         remote_ok_d_r <= 1'b0;
      end else begin
         local_ok_d_r <= local_ok_r;
         remote_ok_d_r <= remote_ok_r;
      end
   end

   always_comb begin
      int_event = '0;
      int_event[`GPS_INT_MS_FAULT] = ms_fault_i && !ms_fault_r;
      int_event[`GPS_INT_IDLE_ERR] = idle_hit;
      int_event[`GPS_INT_LOCAL_LOSS] = local_ok_d_r && !local_ok_r;
      int_event[`GPS_INT_REMOTE_LOSS] = remote_ok_d_r && !remote_ok_r;
   end

   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_status_r <= '0;
      end else if (wr_i && sel_istat) begin
         int_status_r <= (int_status_r & ~wr_data_i[`GPS_INT_W-1:0]) | int_event;
      end else begin
         int_status_r <= int_status_r | int_event;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_mask_r <= '0;
      end else if (wr_i && sel_imask) begin
         int_mask_r <= wr_data_i[`GPS_INT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(int_status_r & int_mask_r);
      end
   end

   always_comb begin
      rd_mux = '0;
      if (sel_status) begin
         rd_mux = status_word;
      end else if (sel_setup) begin
         rd_mux = setup_r;
      end else if (sel_window) begin
         rd_mux = (mode == gps_pkg::GPS_MODE_INDEX) ? index_r : store_rd_data;
      end else if (sel_istat) begin
         rd_mux[`GPS_INT_W-1:0] = int_status_r;
      end else if (sel_imask) begin
         rd_mux[`GPS_INT_W-1:0] = int_mask_r;
      end
   end

   // read data stands for one cycle only, zero otherwise; unmapped reads return zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= '0;
      end else if (rd_i) begin
         rd_data_o <= rd_mux;
      end else begin
         rd_data_o <= '0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op_mode_o <= 2'h0;
         dev_addr_o <= '0;
         reg_index_o <= '0;
      end else begin
         op_mode_o <= setup_r[`GPS_SETUP_MODE_HI:`GPS_SETUP_MODE_LO];
         dev_addr_o <= setup_r[`GPS_DEV_W-1:0];
         reg_index_o <= index_r;
      end
   end
endmodule : gps_top

// *** test/gps_top_monitor.sv ***
// assertion checker for the per-port status and extended-access bank
// assumes the gps_top register port, one clock and the hand-over latencies
`timescale 1ns/100ps
`include "gps_consts.svh"
module gps_top_monitor (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [11:0] addr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rd_data_o,
   input wire logic ms_fault_i,
   input wire logic ms_master_i,
   input wire logic local_rx_ok_i,
   input wire logic remote_rx_ok_i,
   input wire logic lp_fd_i,
   input wire logic lp_hd_i,
   input wire logic [1:0] op_mode_o,
   input wire logic [4:0] dev_addr_o,
   input wire logic [15:0] reg_index_o,
   input wire logic irq_o
);
   logic st_rd, set_wr, win_wr, win_rd, win_acc, mapped;
   logic [1:0] wmode;
   logic [4:0] wdev, live;
   assign st_rd = rd_i && addr_i == `GPS_OFS_LINK_STATUS;
   assign set_wr = wr_i && addr_i == `GPS_OFS_SETUP;
   assign win_wr = wr_i && addr_i == `GPS_OFS_WINDOW;
   assign win_rd = rd_i && addr_i == `GPS_OFS_WINDOW;
   assign win_acc = win_wr || win_rd;
   assign mapped = addr_i inside {`GPS_OFS_LINK_STATUS, `GPS_OFS_SETUP, `GPS_OFS_WINDOW,
      `GPS_OFS_INT_STATUS, `GPS_OFS_INT_MASK};
   assign wmode = wr_data_i[15:14];
   assign wdev = wr_data_i[4:0];
   assign live = {ms_master_i, local_rx_ok_i, remote_rx_ok_i, lp_fd_i, lp_hd_i};
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // outputs lag the setup register by one flop
   a_setup_fields: assert property (set_wr |=> ##1 op_mode_o == $past(wmode, 2) &&
      dev_addr_o == $past(wdev, 2)) else $error("setup fields not mirrored");
   // a read shows the latch as it stood, so the fault must be seen one cycle before the read
   a_fault_sets: assert property (st_rd && $past(ms_fault_i) && $past(rst_n_i) |=> rd_data_o[15])
      else $error("fault bit missing");
   a_fault_clears: assert property (st_rd && !ms_fault_i ##1 !ms_fault_i ##1 st_rd && !ms_fault_i
      |=> !rd_data_o[15]) else $error("fault bit not cleared");
   a_live_bits: assert property (st_rd && $past(rst_n_i)
      |=> rd_data_o[14:8] == {$past(live, 2), 2'b00}) else $error("live status bits wrong");
   a_unmapped_zero: assert property (rd_i && !mapped |=> rd_data_o == 16'h0000)
      else $error("unmapped read not zero");
   a_idx_load: assert property (win_wr && op_mode_o == 2'b00 |=> ##1 reg_index_o == $past(wr_data_i, 2))
      else $error("index not loaded");
   a_idx_fixed: assert property ((win_acc && op_mode_o == 2'b01 || win_rd && op_mode_o == 2'b11)
      |=> ##1 reg_index_o == $past(reg_index_o)) else $error("index moved");
   a_idx_step_rw: assert property (win_acc && op_mode_o == 2'b10
      |=> ##1 reg_index_o == $past(reg_index_o) + 16'h0001) else $error("index not stepped");
   a_idx_step_wr: assert property (win_wr && op_mode_o == 2'b11
      |=> ##1 reg_index_o == $past(reg_index_o) + 16'h0001) else $error("index not stepped on write");
   c_fault_read: cover property (st_rd && ms_fault_i);
   c_step_rw: cover property (win_acc && op_mode_o == 2'b10);
   c_irq: cover property ($rose(irq_o));
endmodule : gps_top_monitor
bind gps_top gps_top_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
   .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .ms_fault_i(ms_fault_i), .ms_master_i(ms_master_i),
   .local_rx_ok_i(local_rx_ok_i), .remote_rx_ok_i(remote_rx_ok_i), .lp_fd_i(lp_fd_i), .lp_hd_i(lp_hd_i),
   .op_mode_o(op_mode_o), .dev_addr_o(dev_addr_o), .reg_index_o(reg_index_o), .irq_o(irq_o));

// *** test/gps_line_model.sv ***
// line-side source of receiver status and idle symbols
// assumes the bench steps its inputs on the rising edge of clk_i
`timescale 1ns/100ps
module gps_line_model (
   input wire logic clk_i,
   input wire logic [5:0] st_i,
   input wire logic go_i,
   input wire logic [3:0] burst_i,
   output logic [5:0] st_o,
   output logic sym_valid_o,
   output logic idle_rx_o,
   output logic send_n_o,
   output logic rx_err_o
);
   logic [3:0] left_r = 4'h0;
   // always idling in send_n mode, so only the error burst decides each step
   assign sym_valid_o = 1'b1;
   assign idle_rx_o = 1'b1;
   assign send_n_o = 1'b1;
   assign rx_err_o = left_r != 4'h0;
   always @(posedge clk_i) begin
      st_o <= st_i;
      left_r <= go_i ? burst_i : left_r - {3'h0, rx_err_o};
   end
endmodule : gps_line_model

// *** test/gps_top_tb_top.sv ***
// self-checking bench for the status and extended-access bank
// assumes gps_top and gps_line_model; one 50 MHz clock
`timescale 1ns/100ps
`include "gps_consts.svh"
module gps_top_tb_top;
   localparam logic [11:0] ST = `GPS_OFS_LINK_STATUS, SU = `GPS_OFS_SETUP, WN = `GPS_OFS_WINDOW;
   localparam logic [11:0] IS = `GPS_OFS_INT_STATUS, IM = `GPS_OFS_INT_MASK;
   logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, go = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [15:0] wr_data_i = 16'h0000, rd_data_o, reg_index_o;
   logic [5:0] st = 6'h00, st_o;
   logic [4:0] dev_addr_o;
   logic [4:0] pats [4] = '{5'h15, 5'h0a, 5'h1f, 5'h00};
   logic [3:0] burst = 4'h0;
   logic [1:0] op_mode_o;
   logic sym_valid, idle_rx, send_n, rx_err, irq_o;
   int bad_count = 0, checks_done = 0;
   initial forever #10 clk_i = ~clk_i;
   gps_line_model u_line (.clk_i(clk_i), .st_i(st), .go_i(go), .burst_i(burst), .st_o(st_o),
      .sym_valid_o(sym_valid), .idle_rx_o(idle_rx), .send_n_o(send_n), .rx_err_o(rx_err));
   gps_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
      .rd_i(rd_i), .rd_data_o(rd_data_o), .ms_fault_i(st_o[5]), .ms_master_i(st_o[4]),
      .local_rx_ok_i(st_o[3]), .remote_rx_ok_i(st_o[2]), .lp_fd_i(st_o[1]), .lp_hd_i(st_o[0]),
      .sym_valid_i(sym_valid), .idle_rx_i(idle_rx), .send_n_i(send_n), .rx_err_i(rx_err),
      .op_mode_o(op_mode_o), .dev_addr_o(dev_addr_o), .reg_index_o(reg_index_o), .irq_o(irq_o));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   // data is looked at only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(rd_data_o, e);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : idle
   task automatic line(input logic [5:0] v);
      @(posedge clk_i);
      st <= v;
      idle(4);
   endtask : line
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (4000) @(posedge clk_i);
      bad_count++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(SU, 16'h0000);
      rd(WN, 16'h0000);
      rd(12'h116, 16'h0000);
      foreach (pats[i]) begin
         line({1'b0, pats[i]});
         rd(ST, {1'b0, pats[i], 10'h000});
      end
      // the pattern walk drops remote ok once and then both receivers
      rd(IS, 16'h000c);
      wr(ST, 16'hffff);
      rd(ST, 16'h0000);
      line(6'h20);
      rd(ST, 16'h8000);
      line(6'h00);
      rd(ST, 16'h8000);
      rd(ST, 16'h0000);
      @(posedge clk_i);
      go <= 1'b1;
      burst <= 4'h5;
      @(posedge clk_i);
      go <= 1'b0;
      idle(8);
      rd(ST, 16'h0005);
      rd(ST, 16'h0000);
      rd(IS, 16'h000f);
      wr(SU, 16'h3fe3);
      rd(SU, 16'h3fe3);
      wr(WN, 16'h0002);
      rd(WN, 16'h0002);
      wr(SU, 16'h4003);
      wr(WN, 16'habcd);
      rd(WN, 16'habcd);
      rd(WN, 16'habcd);
      wr(SU, 16'h8003);
      wr(WN, 16'h1111);
      wr(WN, 16'h2222);
      wr(SU, 16'h0003);
      rd(WN, 16'h0004);
      wr(WN, 16'h0002);
      wr(SU, 16'h8003);
      rd(WN, 16'h1111);
      rd(WN, 16'h2222);
      wr(SU, 16'h0003);
      rd(WN, 16'h0004);
      wr(WN, 16'h0002);
      wr(SU, 16'hc003);
      rd(WN, 16'h1111);
      rd(WN, 16'h1111);
      wr(WN, 16'h3333);
      rd(WN, 16'h2222);
      wr(SU, 16'h0005);
      wr(WN, 16'h0002);
      wr(SU, 16'h4005);
      wr(WN, 16'h5555);
      rd(WN, 16'h5555);
      wr(SU, 16'h4003);
      rd(WN, 16'h3333);
      wr(IS, 16'h000f);
      rd(IS, 16'h0000);
      line(6'h20);
      line(6'h00);
      chk({15'h0000, irq_o}, 16'h0000);
      rd(IS, 16'h0001);
      wr(IM, 16'h0001);
      idle(3);
      chk({15'h0000, irq_o}, 16'h0001);
      rd(IM, 16'h0001);
      wr(IS, 16'h0001);
      idle(3);
      chk({15'h0000, irq_o}, 16'h0000);
      rd(IS, 16'h0000);
      conclude();
   end
endmodule : gps_top_tb_top
